/* File: phy_id_and_an_advert_regs.sv */
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`include "phy_regs_cfg.svh"
module phy_id_and_an_advert_regs #(
	parameter logic [15:0] ID_HIGH_DEF = 16'h0a5a,
	parameter logic [5:0]  OUI_LO_DEF  = 6'h2a,
	parameter logic [5:0]  MODEL_DEF   = 6'h15,
	parameter logic [3:0]  REV_DEF     = 4'h2
) (
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  awaddr_i,
	input  wire logic        awvalid_i,
	output logic             awready_o,
	input  wire logic [31:0] wdata_i,
	input  wire logic [3:0]  wstrb_i,
	input  wire logic        wvalid_i,
	output logic             wready_o,
	output logic [1:0]       bresp_o,
	output logic             bvalid_o,
	input  wire logic        bready_i,
	input  wire logic [7:0]  araddr_i,
	input  wire logic        arvalid_i,
	output logic             arready_o,
	output logic [31:0]      rdata_o,
	output logic [1:0]       rresp_o,
	output logic             rvalid_o,
	input  wire logic        rready_i,
	input  wire logic [1:0]  autoneg_strap_i,
	input  wire logic [1:0]  speed_strap_i,
	input  wire logic [1:0]  duplex_strap_i,
	input  wire logic [1:0]  manual_flow_control_pin_setting_i,
	input  wire logic [1:0]  full_duplex_flow_control_pin_setting_i,
	input  wire logic        loader_wr_i,
	input  wire logic        loader_port_i,
	input  wire logic [15:0] loader_data_i,
	output logic             reload_o,
	output phy_regs_pkg::reg16_t adv_port0_o,
	output phy_regs_pkg::reg16_t adv_port1_o
);
	import phy_regs_pkg::*;

	init_state_e state_ff;
	init_state_e nxt_state;
	logic        run;
	logic        init;

	logic        aw_held_ff;
	logic [7:0]  aw_addr_ff;
	logic        w_held_ff;
	logic [15:0] w_data_ff;
	logic [3:0]  w_strb_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        do_write;
	logic        wr_ok;

	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;
	logic [31:0] rd_word;
	logic        rd_ok;

	logic        reload_ff;
	logic        reload_req;
	logic [1:0]  done_ff;

	logic [1:0]  wr_high;
	logic [1:0]  wr_low;
	logic [1:0]  wr_adv;
	logic [1:0]  load;
	reg16_t      id_high [`NUM_PORTS];
	reg16_t      id_low  [`NUM_PORTS];
	reg16_t      adv     [`NUM_PORTS];
	strap_s      strap_in  [`NUM_PORTS];
	strap_s      strap_cap [`NUM_PORTS];

	function automatic logic reg_hit(input logic [7:0] a);
		logic [2:0] idx;
		idx = a[`IDX_MSB:`IDX_LSB];
		reg_hit = (a[`ADDR_HI_MSB:`ADDR_HI_LSB] == 2'h0) &&
			(a[1:0] == 2'h0) &&
			((idx == `IDX_ID_HIGH) || (idx == `IDX_ID_LOW) ||
			(idx == `IDX_AN_ADV));
	endfunction : reg_hit

	// Release sequence: reset, capture straps, run
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_RESET: begin
				nxt_state = ST_CAPTURE;
			end
			ST_CAPTURE: begin
				nxt_state = ST_RUN;
			end
			ST_RUN: begin
				nxt_state = ST_RUN;
			end
			default: begin
				nxt_state = ST_RESET;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_ff <= ST_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign init = (state_ff == ST_CAPTURE);
	assign run  = (state_ff == ST_RUN);

	// Write address channel
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			aw_held_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
		end else if (awvalid_i && awready_o) begin
			aw_held_ff <= 1'b1;
			aw_addr_ff <= awaddr_i;
		end else if (do_write) begin
			aw_held_ff <= 1'b0;
		end
	end

	// Write data channel
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			w_held_ff <= 1'b0;
			w_data_ff <= 16'h0000;
			w_strb_ff <= 4'h0;
		end else if (wvalid_i && wready_o) begin
			w_held_ff <= 1'b1;
			w_data_ff <= wdata_i[15:0];
			w_strb_ff <= wstrb_i;
		end else if (do_write) begin
			w_held_ff <= 1'b0;
		end
	end

	assign awready_o = run && !aw_held_ff;
	assign wready_o  = run && !w_held_ff;
	assign do_write  = aw_held_ff && w_held_ff && !bvalid_ff;
	assign wr_ok = reg_hit(aw_addr_ff) || (aw_addr_ff == `CTRL_ADDR);

	// Write response
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= `RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bready_i) begin
			bvalid_ff <= 1'b0;
		end
	end

	assign bvalid_o = bvalid_ff;
	assign bresp_o  = bresp_ff;

	// Per-port write strobes
	always_comb begin
		for (int p = 0; p < `NUM_PORTS; p++) begin
			logic sel;
			sel = do_write && reg_hit(aw_addr_ff) &&
				(aw_addr_ff[`PORT_SEL_BIT] == p[0]);
			wr_high[p] = sel &&
				(aw_addr_ff[`IDX_MSB:`IDX_LSB] == `IDX_ID_HIGH);
			wr_low[p] = sel &&
				(aw_addr_ff[`IDX_MSB:`IDX_LSB] == `IDX_ID_LOW);
			wr_adv[p] = sel &&
				(aw_addr_ff[`IDX_MSB:`IDX_LSB] == `IDX_AN_ADV);
			load[p] = loader_wr_i && run &&
				(loader_port_i == p[0]);
		end
	end

	// Reload request, also issued once after release
	assign reload_req = do_write && (aw_addr_ff == `CTRL_ADDR) &&
		w_strb_ff[0] && w_data_ff[`CTRL_RELOAD];

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			reload_ff <= 1'b0;
		end else begin
			reload_ff <= init || reload_req;
		end
	end

	assign reload_o = reload_ff;

	// Loader-done flags, a new load wins over the reload clear
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			done_ff <= 2'h0;
		end else begin
			for (int p = 0; p < `NUM_PORTS; p++) begin
				if (load[p]) begin
					done_ff[p] <= 1'b1;
				end else if (reload_ff) begin
					done_ff[p] <= 1'b0;
				end
			end
		end
	end

	// Port straps grouped per port
	always_comb begin
		for (int p = 0; p < `NUM_PORTS; p++) begin
			strap_in[p].autoneg   = autoneg_strap_i[p];
			strap_in[p].speed     = speed_strap_i[p];
			strap_in[p].duplex    = duplex_strap_i[p];
			strap_in[p].manual_fc = manual_flow_control_pin_setting_i[p];
			strap_in[p].fd_fc = full_duplex_flow_control_pin_setting_i[p];
		end
	end

	genvar g;
	generate
		for (g = 0; g < `NUM_PORTS; g++) begin : g_port
			phy_port_regs #(
				.ID_HIGH_DEF (ID_HIGH_DEF),
				.OUI_LO_DEF  (OUI_LO_DEF),
				.MODEL_DEF   (MODEL_DEF),
				.REV_DEF     (REV_DEF)
			) u_regs (
				.clock_i     (clock_i),
				.rst_i       (rst_i),
				.init_i      (init),
				.strap_i     (strap_in[g]),
				.wr_high_i   (wr_high[g]),
				.wr_low_i    (wr_low[g]),
				.wr_adv_i    (wr_adv[g]),
				.wr_data_i   (w_data_ff),
				.wr_strb_i   (w_strb_ff[1:0]),
				.load_i      (load[g]),
				.load_data_i (loader_data_i),
				.id_high_o   (id_high[g]),
				.id_low_o    (id_low[g]),
				.adv_o       (adv[g]),
				.strap_o     (strap_cap[g])
			);
		end
	endgenerate

	assign adv_port0_o = adv[0];
	assign adv_port1_o = adv[1];

	// Read decode
	always_comb begin
		logic p;
		p = araddr_i[`PORT_SEL_BIT];
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		if (araddr_i == `CTRL_ADDR) begin
			rd_word = 32'h0000_0000;
		end else if (araddr_i == `STAT_ADDR) begin
			rd_word[`STAT_RUN_BIT] = run;
			rd_word[4:0] = strap_cap[0];
			rd_word[`STAT_DONE_OFS] = done_ff[0];
			rd_word[`STAT_P1_LSB +: 5] = strap_cap[1];
			rd_word[`STAT_P1_LSB + `STAT_DONE_OFS] = done_ff[1];
		end else if (reg_hit(araddr_i)) begin
			case (araddr_i[`IDX_MSB:`IDX_LSB])
				`IDX_ID_HIGH: begin
					rd_word[15:0] = id_high[p];
				end
				`IDX_ID_LOW: begin
					rd_word[15:0] = id_low[p];
				end
				`IDX_AN_ADV: begin
					rd_word[15:0] = adv[p];
				end
				default: begin
					rd_ok = 1'b0;
				end
			endcase
		end else begin
			rd_ok = 1'b0;
		end
	end

	assign arready_o = run && !rvalid_ff;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= `RESP_OKAY;
		end else if (arvalid_i && arready_o) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rd_word;
			rresp_ff  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rready_i) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign rvalid_o = rvalid_ff;
	assign rdata_o  = rdata_ff;
	assign rresp_o  = rresp_ff;
endmodule : phy_id_and_an_advert_regs

/* File: phy_id_and_an_advert_regs_checker.sv */
`timescale 1ns/1ps
module phy_id_and_an_advert_regs_checker (
	input wire logic                 clock_i,
	input wire logic                 rst_i,
	input wire logic                 awready_o,
	input wire logic                 wready_o,
	input wire logic [1:0]           bresp_o,
	input wire logic                 bvalid_o,
	input wire logic                 bready_i,
	input wire logic                 arready_o,
	input wire logic [31:0]          rdata_o,
	input wire logic                 rvalid_o,
	input wire logic                 rready_i,
	input wire logic                 loader_wr_i,
	input wire logic                 loader_port_i,
	input wire logic [15:0]          loader_data_i,
	input wire logic                 reload_o,
	input wire phy_regs_pkg::reg16_t adv_port0_o,
	input wire phy_regs_pkg::reg16_t adv_port1_o
);
	import phy_regs_pkg::*;
	logic [1:0] cnt_ff;
	logic       run;
	// Cycles since reset release, saturating
	always_ff @(posedge clock_i) begin
		if (rst_i)
			cnt_ff <= 2'h0;
		else if (cnt_ff != 2'h3)
			cnt_ff <= cnt_ff + 2'h1;
	end
	assign run = (cnt_ff >= 2'h2);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	AST_NO_READY: assert property (
		!run |-> !awready_o && !wready_o && !arready_o)
		else $error("bus ready before straps captured");
	AST_RELOAD: assert property (
		cnt_ff == 2'h1 |=> reload_o)
		else $error("no reload pulse after reset");
	AST_DEF: assert property (
		cnt_ff == 2'h1 |=> adv_port0_o[13:12] == 2'h0 &&
		adv_port0_o[8:7] == 2'h3 && adv_port1_o[4:0] == 5'h01)
		else $error("advert fixed defaults wrong");
	AST_RSV: assert property (
		adv_port0_o[15:14] == 2'h0 && !adv_port0_o[9] &&
		adv_port1_o[15:14] == 2'h0 && !adv_port1_o[9])
		else $error("reserved advert bits not zero");
	AST_LOAD0: assert property (
		run && loader_wr_i && !loader_port_i |=>
		adv_port0_o == ($past(loader_data_i) & 16'h3dff))
		else $error("loader write to port 0 lost");
	AST_LOAD1: assert property (
		run && loader_wr_i && loader_port_i |=>
		adv_port1_o == ($past(loader_data_i) & 16'h3dff))
		else $error("loader write to port 1 lost");
	AST_RHOLD: assert property (
		rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
		else $error("read data dropped before taken");
	AST_BHOLD: assert property (
		bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
		else $error("write response dropped before taken");
endmodule : phy_id_and_an_advert_regs_checker

bind phy_id_and_an_advert_regs phy_id_and_an_advert_regs_checker chk (
	.clock_i, .rst_i, .awready_o, .wready_o, .bresp_o, .bvalid_o,
	.bready_i, .arready_o, .rdata_o, .rvalid_o, .rready_i, .loader_wr_i,
	.loader_port_i, .loader_data_i, .reload_o, .adv_port0_o, .adv_port1_o
);

/* File: phy_id_and_an_advert_regs_tb_top.sv */
`timescale 1ns/1ps
`include "phy_regs_cfg.svh"
module phy_id_and_an_advert_regs_tb_top;
	import phy_regs_pkg::*;
	// Arbitrary identity values
	localparam logic [15:0] IDH = 16'h1c3e;
	localparam logic [5:0]  OUL = 6'h0b;
	localparam logic [5:0]  MDL = 6'h27;
	localparam logic [3:0]  RVN = 4'h9;
	localparam logic [1:0]  OK  = `RESP_OKAY;
	localparam logic [1:0]  ERR = `RESP_SLVERR;
	logic        clock_i = 1'h0;
	logic        rst_i = 1'h1;
	logic [7:0]  awaddr_i = 8'h0, araddr_i = 8'h0;
	logic        awvalid_i = 1'h0, wvalid_i = 1'h0, bready_i = 1'h0;
	logic        arvalid_i = 1'h0, rready_i = 1'h0;
	logic [31:0] wdata_i = 32'h0;
	logic [3:0]  wstrb_i = 4'h0;
	logic [1:0]  autoneg_strap_i = 2'h0, speed_strap_i = 2'h0;
	logic [1:0]  duplex_strap_i = 2'h0;
	logic [1:0]  manual_flow_control_pin_setting_i = 2'h0;
	logic [1:0]  full_duplex_flow_control_pin_setting_i = 2'h0;
	logic        loader_wr_i = 1'h0, loader_port_i = 1'h0;
	logic [15:0] loader_data_i = 16'h0;
	logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
	logic        reload_o;
	logic [1:0]  bresp_o, rresp_o;
	logic [31:0] rdata_o;
	reg16_t      adv_port0_o, adv_port1_o;
	int          error_cnt = 0, total_checks = 0, pulses = 0;

	phy_id_and_an_advert_regs #(.ID_HIGH_DEF(IDH), .OUI_LO_DEF(OUL),
		.MODEL_DEF(MDL), .REV_DEF(RVN)) uut (
		.clock_i, .rst_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i,
		.wstrb_i, .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i,
		.araddr_i, .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o,
		.rready_i, .autoneg_strap_i, .speed_strap_i, .duplex_strap_i,
		.manual_flow_control_pin_setting_i,
		.full_duplex_flow_control_pin_setting_i, .loader_wr_i,
		.loader_port_i, .loader_data_i, .reload_o, .adv_port0_o,
		.adv_port1_o);

	always #10 clock_i = ~clock_i;
	always @(posedge clock_i) if (reload_o === 1'h1) pulses++;

	task automatic chk(input string nm, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wchk(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic at, wt, bt;
		logic [1:0] r;
		@(posedge clock_i);
		awaddr_i <= a;
		wdata_i <= d;
		wstrb_i <= 4'hf;
		awvalid_i <= 1'h1;
		wvalid_i <= 1'h1;
		bready_i <= 1'h1;
		for (int n = 0; n < 50; n++) begin
			@(negedge clock_i);
			at = awready_o;
			wt = wready_o;
			bt = bvalid_o;
			r = bresp_o;
			@(posedge clock_i);
			if (at) awvalid_i <= 1'h0;
			if (wt) wvalid_i <= 1'h0;
			if (bt) break;
		end
		bready_i <= 1'h0;
		chk("bresp", {30'h0, er}, {30'h0, r});
	endtask : wchk

	task automatic rchk(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic at, vt;
		logic [1:0] r;
		logic [31:0] d;
		@(posedge clock_i);
		araddr_i <= a;
		arvalid_i <= 1'h1;
		rready_i <= 1'h1;
		for (int n = 0; n < 50; n++) begin
			@(negedge clock_i);
			at = arready_o;
			vt = rvalid_o;
			d = rdata_o;
			r = rresp_o;
			@(posedge clock_i);
			if (at) arvalid_i <= 1'h0;
			if (vt) break;
		end
		rready_i <= 1'h0;
		chk("rdata", e, d);
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask : rchk

	function automatic logic [15:0] ae(input logic [4:0] s);
		return {4'h0, ~s[1] & s[0], ~s[1], 1'h0, 2'h3,
			s[4] | (~s[3] & s[2]), s[4] | ~s[3], 5'h01};
	endfunction : ae

	// Strap word is {autoneg, speed, duplex, manual fc, fd fc}
	task automatic straps(input logic [4:0] s0, s1);
		@(posedge clock_i);
		autoneg_strap_i <= {s1[4], s0[4]};
		speed_strap_i <= {s1[3], s0[3]};
		duplex_strap_i <= {s1[2], s0[2]};
		manual_flow_control_pin_setting_i <= {s1[1], s0[1]};
		full_duplex_flow_control_pin_setting_i <= {s1[0], s0[0]};
	endtask : straps

	task automatic t_straps;
		logic [4:0] s;
		int p;
		for (int i = 0; i < 32; i++) begin
			s = i[4:0];
			straps(s, ~s);
			p = pulses;
			rst_i <= 1'h1;
			repeat (20) @(posedge clock_i);
			rst_i <= 1'h0;
			repeat (3) @(posedge clock_i);
			@(negedge clock_i);
			chk("adv0", ae(s), adv_port0_o);
			chk("adv1", ae(~s), adv_port1_o);
			chk("reload", p + 1, pulses);
			straps(~s, s);
			repeat (2) @(posedge clock_i);
			@(negedge clock_i);
			chk("held", ae(s), adv_port0_o);
		end
	endtask : t_straps

	task automatic t_ids;
		rchk(8'h08, {16'h0, IDH}, OK);
		rchk(8'h2c, {16'h0, OUL, MDL, RVN}, OK);
		wchk(8'h08, 32'hffff_a55a, OK);
		rchk(8'h08, 32'h0000_a55a, OK);
		wchk(8'h0c, 32'h0000_5a3c, OK);
		rchk(8'h0c, 32'h0000_5a3c, OK);
		rchk(8'h2c, {16'h0, OUL, MDL, RVN}, OK);
	endtask : t_ids

	task automatic t_adv;
		wchk(8'h10, 32'h0000_ffff, OK);
		rchk(8'h10, 32'h0000_3dff, OK);
		wchk(8'h30, 32'h0, OK);
		rchk(8'h30, 32'h0, OK);
	endtask : t_adv

	task automatic t_loader;
		@(posedge clock_i);
		loader_wr_i <= 1'h1;
		loader_port_i <= 1'h1;
		loader_data_i <= 16'hffff;
		@(posedge clock_i);
		loader_wr_i <= 1'h0;
		@(negedge clock_i);
		chk("ld1", 32'h3dff, {16'h0, adv_port1_o});
		chk("ld0", 32'h3dff, {16'h0, adv_port0_o});
	endtask : t_loader

	task automatic t_reload;
		int p;
		p = pulses;
		wchk(8'h40, 32'h1, OK);
		repeat (3) @(posedge clock_i);
		chk("cmd", p + 1, pulses);
		rchk(8'h14, 32'h0, ERR);
		wchk(8'h44, 32'h0, ERR);
	endtask : t_reload

	task automatic stop_test;
		$display("errors %0d checks %0d", error_cnt, total_checks);
		if (error_cnt == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test

	initial begin
		t_straps;
		t_ids;
		t_adv;
		t_loader;
		t_reload;
		stop_test;
	end

	initial begin
		#200000;
		error_cnt++;
		stop_test;
	end
endmodule : phy_id_and_an_advert_regs_tb_top

/* File: phy_port_regs.sv */
`timescale 1ns/1ps
`include "phy_regs_cfg.svh"
module phy_port_regs #(
	parameter logic [15:0] ID_HIGH_DEF = 16'h0a5a,
	parameter logic [5:0]  OUI_LO_DEF  = 6'h2a,
	parameter logic [5:0]  MODEL_DEF   = 6'h15,
	parameter logic [3:0]  REV_DEF     = 4'h2
) (
	input  wire logic                 clock_i,
	input  wire logic                 rst_i,
	input  wire logic                 init_i,
	input  wire phy_regs_pkg::strap_s strap_i,
	input  wire logic                 wr_high_i,
	input  wire logic                 wr_low_i,
	input  wire logic                 wr_adv_i,
	input  wire logic [15:0]          wr_data_i,
	input  wire logic [1:0]           wr_strb_i,
	input  wire logic                 load_i,
	input  wire logic [15:0]          load_data_i,
	output phy_regs_pkg::reg16_t      id_high_o,
	output phy_regs_pkg::reg16_t      id_low_o,
	output phy_regs_pkg::reg16_t      adv_o,
	output phy_regs_pkg::strap_s      strap_o
);
	import phy_regs_pkg::*;

	reg16_t id_high_ff;
	reg16_t id_low_ff;
	reg16_t adv_ff;
	strap_s strap_ff;

	function automatic reg16_t merge(input reg16_t old, input reg16_t nw,
		input logic [1:0] strb);
		merge = {strb[1] ? nw[15:8] : old[15:8],
			strb[0] ? nw[7:0] : old[7:0]};
	endfunction : merge

	function automatic reg16_t adv_default(input strap_s s);
		reg16_t v;
		v = 16'h0000;
		v[`ADV_RF_BIT] = `ADV_RF_RST;
		v[`ADV_RSV_BIT] = `ADV_RSV_RST;
		v[`ADV_SYM_BIT] = ~s.manual_fc;
		v[`ADV_ASYM_BIT] = ~s.manual_fc & s.fd_fc;
		v[`ADV_FD100_BIT] = `ADV_100_RST;
		v[`ADV_HD100_BIT] = `ADV_100_RST;
		v[`ADV_FD10_BIT] = s.autoneg | (~s.speed & s.duplex);
		v[`ADV_HD10_BIT] = s.autoneg | ~s.speed;
		v[`ADV_SEL_MSB:`ADV_SEL_LSB] = `ADV_SEL_RST;
		adv_default = v;
	endfunction : adv_default

	// Strap copy for this port only
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			strap_ff <= '0;
		end else if (init_i) begin
			strap_ff <= strap_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			id_high_ff <= ID_HIGH_DEF;
		end else if (wr_high_i) begin
			id_high_ff <= merge(id_high_ff, wr_data_i, wr_strb_i);
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			id_low_ff <= {OUI_LO_DEF, MODEL_DEF, REV_DEF};
		end else if (wr_low_i) begin
			id_low_ff <= merge(id_low_ff, wr_data_i, wr_strb_i);
		end
	end

	// Loader wins over a software write in the same cycle
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			adv_ff <= adv_default('0);
		end else if (init_i) begin
			adv_ff <= adv_default(strap_i);
		end else if (load_i) begin
			adv_ff <= load_data_i & `ADV_WR_MASK;
		end else if (wr_adv_i) begin
			adv_ff <= merge(adv_ff, wr_data_i, wr_strb_i) & `ADV_WR_MASK;
		end
	end

	assign id_high_o = id_high_ff;
	assign id_low_o  = id_low_ff;
	assign adv_o     = adv_ff;
	assign strap_o   = strap_ff;
endmodule : phy_port_regs

/* File: phy_regs_cfg.svh */
`ifndef PHY_REGS_CFG_SVH
`define PHY_REGS_CFG_SVH
// Contract
// - The ID high register holds OUI bits 3 to 18 in bits 15:0, RW.
// - The ID low register holds OUI bits 19 to 24 in bits 15:10, RW.
// - The ID low register holds a 6-bit model number in bits 9:4, RW.
// - The ID low register holds a 4-bit revision in bits 3:0, RW.
// - The loader rewrites the advertisement after reset and reload.
// - Advert bit 13 is RW remote fault advertisement, reset 0.
// - Advert bit 11 is asymmetric pause, bit 10 symmetric pause, RW.
// - Advert bits 8 and 7 are RW 100BASE-X full/half duplex, reset 1.
// - Advert bits 4:0 are an RW selector field, reset 00001b.
// - Manual strap 0 gives sym 1 and asym from the FD strap, else 0.
// - Advert bit 6 defaults to autoneg OR (NOT speed AND duplex).
// - Advert bit 5 defaults to autoneg OR NOT speed.
// - Straps are caught as reset is released and held until reset.

`define NUM_PORTS      2
`define IDX_ID_HIGH    3'h2
`define IDX_ID_LOW     3'h3
`define IDX_AN_ADV     3'h4
`define PORT_SEL_BIT   5
`define IDX_MSB        4
`define IDX_LSB        2
`define ADDR_HI_MSB    7
`define ADDR_HI_LSB    6
`define CTRL_ADDR      8'h40
`define STAT_ADDR      8'h44
`define CTRL_RELOAD    0
`define STAT_P1_LSB    8
`define STAT_DONE_OFS  5
`define STAT_RUN_BIT   16
`define OUI_LO_LSB     10
`define MODEL_LSB      4
`define REV_LSB        0
`define ADV_WR_MASK    16'h3dff
`define ADV_RF_BIT     13
`define ADV_RSV_BIT    12
`define ADV_ASYM_BIT   11
`define ADV_SYM_BIT    10
`define ADV_FD100_BIT  8
`define ADV_HD100_BIT  7
`define ADV_FD10_BIT   6
`define ADV_HD10_BIT   5
`define ADV_SEL_MSB    4
`define ADV_SEL_LSB    0
`define ADV_RF_RST     1'h0
`define ADV_RSV_RST    1'h0
`define ADV_100_RST    1'h1
`define ADV_SEL_RST    5'h01
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

/* File: phy_regs_pkg.sv */
package phy_regs_pkg;
	typedef logic [15:0] reg16_t;
	typedef enum logic [1:0] {
		ST_RESET   = 2'h0,
		ST_CAPTURE = 2'h1,
		ST_RUN     = 2'h3
	} init_state_e;
	typedef struct packed {
		logic autoneg;
		logic speed;
		logic duplex;
		logic manual_fc;
		logic fd_fc;
	} strap_s;
endpackage : phy_regs_pkg
